// file: include/spi_port_cfg.svh
// Constants for the serial register port, shared by both ends
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SPI_ADDR_W 6
`define SPI_BYTE_W 8
`define SPI_LAST_BIT 3'h7
`define SPI_BIT_ONE 3'h1
`define SPI_RW_POS 7
`define SPI_ADDR_ONE 6'h01

// ----------------------------------------------------------------
// Timing: core clock and link clock periods in ns
// ----------------------------------------------------------------
`define SPI_CORE_NS 50
`define SPI_SCLK_NS 400
`define SPI_HALF_CYC ((`SPI_SCLK_NS / 2) / `SPI_CORE_NS)

`endif

// file: include/spi_port_pkg.sv
// Types shared by the device end and the master end of the register port
`default_nettype none
`include "spi_port_cfg.svh"

package spi_port_pkg;

  // ----------------------------------------------------------------
  // Device end
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_HDR = 2'b01,
    DEV_DATA = 2'b10
  } dev_phase_e;

  typedef struct packed {
    logic [1:0] sclk_sy;
    logic [1:0] cs_sy;
    logic [1:0] mosi_sy;
    logic sclk_q;
    logic cs_q;
    logic pol;
    dev_phase_e phase;
    logic [2:0] bit_cnt;
    logic rd;
    logic [`SPI_ADDR_W-1:0] addr;
    logic [`SPI_BYTE_W-1:0] shreg;
    logic load;
    logic miso;
    logic miso_oe;
    logic [`SPI_ADDR_W-1:0] reg_addr;
    logic [`SPI_BYTE_W-1:0] wdata;
    logic wr;
    logic rdreq;
  } dev_state_s;

  // ----------------------------------------------------------------
  // Master end
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_XFER = 3'b010,
    H_TAIL = 3'b011,
    H_GAP = 3'b100
  } host_state_e;

  typedef struct packed {
    host_state_e st;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [1:0] miso_sy;
    logic rd;
    logic half;
    logic hdr;
    logic [2:0] bit_cnt;
    logic [7:0] left;
    logic [`SPI_BYTE_W-1:0] tx;
    logic [`SPI_BYTE_W-1:0] rx;
    logic cap;
    logic cap_last;
    logic [`SPI_BYTE_W-1:0] rdata;
    logic rvalid;
    logic done;
    logic rdy;
  } host_state_s;

endpackage : spi_port_pkg

`default_nettype wire

// file: include/spi_port_if.sv
// Four-wire link between the master end and the device end
`timescale 1ns/1ns
`default_nettype none

interface spi_port_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_drv;
  logic miso_oe;
  logic miso;

  // Data-out line level: pulled high while the device does not drive it
  assign miso = miso_oe ? miso_drv : 1'b1;

  modport dev_mp (input sclk, input cs_n, input mosi, output miso_drv, output miso_oe);
  modport host_mp (output sclk, output cs_n, output mosi, input miso);
endinterface : spi_port_if

`default_nettype wire

// file: rtl/spi_dev_end.sv
// Device end of the serial register port: slave engine toward a register file
`include "spi_port_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module spi_dev_end
  import spi_port_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  spi_port_if.dev_mp link,
  output logic [`SPI_ADDR_W-1:0] reg_addr_o,
  output logic [`SPI_BYTE_W-1:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [`SPI_BYTE_W-1:0] reg_rdata_i
);

  // Every link edge reaches this logic three core cycles late, through the
  // synchroniser and the edge detector. A half period of the link clock must
  // therefore last at least four core cycles, or a read bit would only leave
  // after the master has already sampled it.

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Register pointer step; wraps at the top of the address space
  function automatic logic [`SPI_ADDR_W-1:0] next_addr(input logic [`SPI_ADDR_W-1:0] a);
    next_addr = a + `SPI_ADDR_ONE;
  endfunction : next_addr

  // Pick one of the two clock edges by the latched polarity
  function automatic logic edge_pick(input logic hi, input logic rise, input logic fall);
    edge_pick = hi ? rise : fall;
  endfunction : edge_pick

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Synchroniser stages and their delayed copies sit in the same struct as
  // the frame state, so enable low freezes them together: no link edge is
  // lost or invented while the block is held, at the cost of the master
  // having to be held as well.
  dev_state_s s;
  dev_state_s next_s;

  logic sclk_rise;
  logic sclk_fall;
  logic samp;
  logic launch;
  logic cs_lvl;
  logic cs_fall;
  logic cs_rise;
  logic rd_data;
  logic [`SPI_BYTE_W-1:0] in_byte;

  // Edge detection works on the second synchroniser stage only
  assign sclk_rise = s.sclk_sy[1] & ~s.sclk_q;
  assign sclk_fall = ~s.sclk_sy[1] & s.sclk_q;
  assign cs_lvl = s.cs_sy[1];
  assign cs_fall = ~cs_lvl & s.cs_q;
  assign cs_rise = cs_lvl & ~s.cs_q;

  // Sampling and launch edges swap with the latched polarity
  assign samp = edge_pick(s.pol, sclk_rise, sclk_fall);
  assign launch = edge_pick(s.pol, sclk_fall, sclk_rise);

  // Read data phase: the input line is ignored, only the output counts
  assign rd_data = (s.phase == DEV_DATA) && s.rd;

  // Byte as it stands after the current sampling edge
  assign in_byte = {s.shreg[`SPI_BYTE_W-2:0], s.mosi_sy[1]};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // One pass over the whole state; pulses fall back to zero each cycle
  always_comb begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.rdreq = 1'b0;
    next_s.load = 1'b0;

    // Link pins cross into the core clock through two stages
    next_s.sclk_sy = {s.sclk_sy[0], link.sclk};
    next_s.cs_sy = {s.cs_sy[0], link.cs_n};
    next_s.mosi_sy = {s.mosi_sy[0], link.mosi};
    next_s.sclk_q = s.sclk_sy[1];
    next_s.cs_q = s.cs_sy[1];

    // Register file answers in the same cycle as the address is shown
    if (s.load) begin
      next_s.shreg = reg_rdata_i;
    end

    // Nothing happens without a select from the master
    if (cs_lvl || cs_rise) begin
      // Any partial byte is simply forgotten here
      next_s.phase = DEV_IDLE;
      next_s.miso_oe = 1'b0;
      next_s.bit_cnt = 3'h0;
    end else if (cs_fall) begin
      // Polarity held for the whole frame from the clock level now
      next_s.pol = s.sclk_sy[1];
      next_s.phase = DEV_HDR;
      next_s.bit_cnt = 3'h0;
      next_s.miso_oe = 1'b0;
    end else if (s.phase != DEV_IDLE) begin
      // Receive shift on every sampling edge unless reading
      if (samp && !rd_data) begin
        next_s.shreg = in_byte;
      end

      // Transmit shift on every launch edge of the read data phase
      if (launch && rd_data) begin
        next_s.miso = s.shreg[`SPI_BYTE_W-1];
        next_s.shreg = {s.shreg[`SPI_BYTE_W-2:0], 1'b0};
        next_s.miso_oe = 1'b1;
      end

      // Count sampling edges; the eighth one closes a byte
      if (samp) begin
        next_s.bit_cnt = s.bit_cnt + `SPI_BIT_ONE;
        if (s.bit_cnt == `SPI_LAST_BIT) begin
          if (s.phase == DEV_HDR) begin
            // First bit is the command, second is ignored, six address bits
            next_s.phase = DEV_DATA;
            next_s.rd = in_byte[`SPI_RW_POS];
            next_s.addr = in_byte[`SPI_ADDR_W-1:0];
            next_s.reg_addr = in_byte[`SPI_ADDR_W-1:0];
            next_s.rdreq = in_byte[`SPI_RW_POS];
            next_s.load = in_byte[`SPI_RW_POS];
          end else if (s.rd) begin
            // Fetch the following register before its first launch edge
            next_s.addr = next_addr(s.addr);
            next_s.reg_addr = next_addr(s.addr);
            next_s.rdreq = 1'b1;
            next_s.load = 1'b1;
          end else begin
            // Whole byte arrived: commit, then step the pointer
            next_s.wdata = in_byte;
            next_s.reg_addr = s.addr;
            next_s.wr = 1'b1;
            next_s.addr = next_addr(s.addr);
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Enable low freezes everything, synchronisers included
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      // Select reads as idle from the start, so no false select edge
      // is seen in the first cycles after reset
      s.cs_sy <= 2'h3;
      s.cs_q <= 1'h1;
    end else if (en_i) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Register side, straight from the state register
  assign reg_addr_o = s.reg_addr;
  assign reg_wdata_o = s.wdata;
  assign reg_wr_o = s.wr;
  assign reg_rd_o = s.rdreq;

  // Link side: the data-out line is let go whenever select is high
  assign link.miso_drv = s.miso;
  assign link.miso_oe = s.miso_oe;

endmodule : spi_dev_end

`default_nettype wire

// file: rtl/spi_host_end.sv
// Master end of the serial register port, with its write-data FIFO
`include "spi_port_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Write-data FIFO
// ----------------------------------------------------------------
module spi_byte_fifo #(
  parameter int WIDTH = `SPI_BYTE_W,
  parameter int DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic full;
  } fifo_state_s;

  fifo_state_s s;
  fifo_state_s next_s;
  logic push;
  logic pop;

  // Pointer step that also suits depths other than powers of two
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  assign push = in_valid_i && !s.full;
  assign pop = out_ready_i && (s.cnt != '0);

  // Full is kept as a register so the ready output has no logic behind it
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp = ptr_inc(s.wp);
    end
    if (pop) begin
      next_s.rp = ptr_inc(s.rp);
    end
    next_s.cnt = s.cnt + CW'(push) - CW'(pop);
    next_s.full = (next_s.cnt == CW'(DEPTH));
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else if (en_i) begin
      s <= next_s;
    end
  end

  assign in_ready_o = !s.full;
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o = s.mem[s.rp];
endmodule : spi_byte_fifo

// ----------------------------------------------------------------
// Master engine
// ----------------------------------------------------------------
module spi_host_end
  import spi_port_pkg::*;
#(
  parameter int HALF_CYC = `SPI_HALF_CYC,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  spi_port_if.host_mp link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_rd_i,
  input wire logic cmd_pol_i,
  input wire logic [`SPI_ADDR_W-1:0] cmd_addr_i,
  input wire logic [7:0] cmd_len_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [`SPI_BYTE_W-1:0] wr_data_i,
  output logic [`SPI_BYTE_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic done_o
);
  host_state_s s;
  host_state_s next_s;
  logic tick;
  logic stall;
  logic pop;
  logic cap_now;
  logic f_valid;
  logic [`SPI_BYTE_W-1:0] f_data;
  logic [`SPI_BYTE_W-1:0] rx_new;

  spi_byte_fifo #(.WIDTH(`SPI_BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(en_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(pop),
    .out_data_o(f_data)
  );

  assign tick = (s.div == 8'(HALF_CYC - 1));
  // Empty FIFO at a write byte boundary holds the link clock still
  assign stall = (s.st == H_XFER) && !s.half && !s.hdr && !s.rd && (s.bit_cnt == 3'h0) && !f_valid;
  assign pop = tick && !stall && (s.st == H_XFER) && !s.half && !s.hdr && !s.rd && (s.bit_cnt == 3'h0);
  // Read bits are taken a half period late, covering both synchronisers
  assign cap_now = tick && s.cap && (((s.st == H_XFER) && !s.half && !stall) || (s.st == H_TAIL));
  assign rx_new = {s.rx[`SPI_BYTE_W-2:0], s.miso_sy[1]};

  // Sequencer: every half period of the link clock is one step
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.done = 1'b0;
    next_s.miso_sy = {s.miso_sy[0], link.miso};
    next_s.div = ((s.st == H_IDLE) || tick) ? 8'h00 : s.div + 8'h01;
    if (stall) begin
      next_s.div = s.div;
    end
    if (cap_now) begin
      next_s.rx = rx_new;
      next_s.cap = 1'b0;
      if (s.cap_last) begin
        next_s.rdata = rx_new;
        next_s.rvalid = 1'b1;
      end
    end
    unique case (s.st)
      H_IDLE: begin
        next_s.rdy = 1'b1;
        if (cmd_valid_i && s.rdy) begin
          // Clock set to the chosen level in the same cycle as select falls
          next_s.sclk = cmd_pol_i;
          next_s.cs_n = 1'b0;
          next_s.rd = cmd_rd_i;
          next_s.tx = {cmd_rd_i, 1'b0, cmd_addr_i};
          next_s.left = cmd_len_i;
          next_s.hdr = 1'b1;
          next_s.half = 1'b0;
          next_s.bit_cnt = 3'h0;
          next_s.rdy = 1'b0;
          next_s.st = H_SETUP;
        end
      end
      H_SETUP: begin
        if (tick) begin
          next_s.st = H_XFER;
        end
      end
      H_XFER: begin
        if (tick && !stall) begin
          next_s.sclk = ~s.sclk;
          next_s.half = ~s.half;
          if (!s.half) begin
            // Launch edge
            if (pop) begin
              next_s.mosi = f_data[`SPI_BYTE_W-1];
              next_s.tx = {f_data[`SPI_BYTE_W-2:0], 1'b0};
            end else begin
              next_s.mosi = s.tx[`SPI_BYTE_W-1];
              next_s.tx = {s.tx[`SPI_BYTE_W-2:0], 1'b0};
            end
          end else begin
            // Sampling edge
            next_s.bit_cnt = s.bit_cnt + `SPI_BIT_ONE;
            if (!s.hdr && s.rd) begin
              next_s.cap = 1'b1;
              next_s.cap_last = (s.bit_cnt == `SPI_LAST_BIT);
            end
            if (s.bit_cnt == `SPI_LAST_BIT) begin
              next_s.hdr = 1'b0;
              if (!s.hdr) begin
                next_s.left = s.left - 8'h01;
              end
              if ((s.hdr && (s.left == 8'h00)) || (!s.hdr && (s.left == 8'h01))) begin
                next_s.st = H_TAIL;
              end
            end
          end
        end
      end
      H_TAIL: begin
        if (tick) begin
          next_s.cs_n = 1'b1;
          next_s.st = H_GAP;
        end
      end
      H_GAP: begin
        // Select stays high a half period before the next frame
        if (tick) begin
          next_s.done = 1'b1;
          next_s.st = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.cs_n <= 1'b1;
    end else if (en_i) begin
      s <= next_s;
    end
  end

  assign link.sclk = s.sclk;
  assign link.cs_n = s.cs_n;
  assign link.mosi = s.mosi;
  assign cmd_ready_o = s.rdy;
  assign rd_data_o = s.rdata;
  assign rd_valid_o = s.rvalid;
  assign done_o = s.done;
endmodule : spi_host_end

`default_nettype wire

// file: verif/spi_port_chk.sv
// Concurrent checks on the four-wire link between the two ends
`timescale 1ns/1ns
`default_nettype none

module spi_port_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_drv,
  input wire logic miso_oe,
  input wire logic miso
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Frame tracker
  // ----------------------------------------------------------------
  logic sq, cq, pol, rw, samp, launch;
  logic [7:0] cnt;
  logic [3:0] since;
  // Edges count only once select was already low, so the level set at select fall is not an edge
  assign samp = !cs_n && !cq && sclk != sq && sclk == pol;
  assign launch = !cs_n && !cq && sclk != sq && sclk != pol;

  // Polarity at select fall, sampling-edge count, command bit, cycles since launch
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sq <= 1'h0;
      cq <= 1'h1;
      pol <= 1'h0;
      rw <= 1'h0;
      cnt <= 8'h00;
      since <= 4'hF;
    end else begin
      sq <= sclk;
      cq <= cs_n;
      if (!cs_n && cq) begin
        pol <= sclk;
        cnt <= 8'h00;
      end else if (samp) begin
        cnt <= cnt + 8'h01;
        if (cnt == 8'h00) begin
          rw <= mosi;
        end
      end
      if (launch) begin
        since <= 4'h0;
      end else if (since != 4'hF) begin
        since <= since + 4'h1; // Saturates: long stalls must not wrap
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sclk_idle_still_a:
  assert property ($changed(sclk) |-> !cs_n) else $error("serial clock moved outside a frame");
  oe_release_a:
  assert property (cs_n [*8] |-> !miso_oe) else $error("data out still driven after select rose");
  hdr_quiet_a:
  assert property (!cs_n && cnt != 8'h00 && cnt < 8'h08 |-> !miso_oe) else $error("data out driven in header");
  write_quiet_a:
  assert property (!cs_n && !rw && cnt != 8'h00 |-> !miso_oe) else $error("data out driven in write frame");
  read_drive_a:
  assert property (samp && rw && cnt >= 8'h08 |-> miso_oe) else $error("read bit not driven at sampling edge");
  miso_on_launch_a:
  assert property (!cs_n && miso_oe && $changed(miso_drv) |-> since < 4'h4) else $error("data out moved off launch");
  mosi_on_launch_a:
  assert property (!cs_n && !cq && $changed(mosi) |-> launch) else $error("data in moved off launch edge");
  frame_whole_a:
  assert property ($rose(cs_n) |-> cnt[2:0] == 3'h0 && cnt != 8'h00) else $error("frame ended mid byte");
  pol_held_a:
  assert property ($rose(cs_n) |-> sclk == pol) else $error("clock idle level changed within frame");
  rsvd_bit_zero_a:
  assert property (samp && cnt == 8'h01 |-> !mosi) else $error("reserved header bit not zero");

  cover property (samp && rw && cnt == 8'h0F);
  cover property ($rose(cs_n) && cnt == 8'h18);
  cover property ($fell(cs_n) && sclk);
endmodule : spi_port_chk

`default_nettype wire

// file: verif/spi_slave_register_port_tb_top.sv
// Bench joining the master end and the device end, plus a second device end on a hand-driven link
`timescale 1ns/1ns
`default_nettype none

module spi_slave_register_port_tb_top;
  typedef struct packed {logic rd; logic pol; logic [5:0] a; logic [7:0] n; logic [15:0] d;} row_s;
  localparam int LIMIT = 10000;
  logic clk, rst_n, en, cmd_valid, cmd_ready, cmd_rd, cmd_pol, wr_valid, wr_ready, rd_valid, done;
  logic reg_wr, reg_rd, wr_b, sq, cq;
  logic [5:0] cmd_addr, reg_addr, addr_b;
  logic [7:0] cmd_len, wr_data, rd_data, reg_wdata, wd_b;
  logic [7:0] regs [64];
  logic [31:0] mo, mi;
  logic [13:0] wq [$];
  logic [7:0] rq [$];
  logic [5:0] aq [$];
  int mismatches, checks_done, cyc, wr_cnt2;
  row_s r;
  row_s rows [5] = '{'{1'h0, 1'h0, 6'h05, 8'h01, 16'hA500}, '{1'h0, 1'h1, 6'h3F, 8'h02, 16'h3CC3},
    '{1'h1, 1'h0, 6'h05, 8'h01, 16'hA500}, '{1'h1, 1'h1, 6'h3F, 8'h02, 16'h3CC3},
    '{1'h0, 1'h1, 6'h10, 8'h00, 16'h0000}};

  spi_port_if lnk ();
  spi_port_if lnk_b ();
  spi_host_end #(.HALF_CYC(4), .FIFO_DEPTH(4)) i_spi_host_end (.core_clk_i(clk), .rst_n_i(rst_n), .en_i(en),
    .link(lnk), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_rd_i(cmd_rd), .cmd_pol_i(cmd_pol),
    .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready),
    .wr_data_i(wr_data), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .done_o(done));
  spi_dev_end i_spi_dev_end (.core_clk_i(clk), .rst_n_i(rst_n), .en_i(en), .link(lnk), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(regs[reg_addr]));
  spi_dev_end i_spi_dev_end_b (.core_clk_i(clk), .rst_n_i(rst_n), .en_i(en), .link(lnk_b), .reg_addr_o(addr_b),
    .reg_wdata_o(wd_b), .reg_wr_o(wr_b), .reg_rd_o(), .reg_rdata_i(8'h00));
  spi_port_chk i_spi_port_chk (.core_clk_i(clk), .rst_n_i(rst_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .mosi(lnk.mosi), .miso_drv(lnk.miso_drv), .miso_oe(lnk.miso_oe), .miso(lnk.miso));

  // ----------------------------------------------------------------
  // Register file, logs, wire sniffer and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sq <= lnk.sclk;
    cq <= lnk.cs_n;
    if (reg_wr) begin
      regs[reg_addr] <= reg_wdata;
      wq.push_back({reg_addr, reg_wdata});
    end
    if (rd_valid) rq.push_back(rd_data);
    if (reg_rd) aq.push_back(reg_addr); // Fetch log for the read pointer
    if (wr_b) wr_cnt2 <= wr_cnt2 + 1;
    // Sniffer relies on the command fields staying put for the whole frame
    if (!lnk.cs_n && !cq && lnk.sclk != sq && lnk.sclk == cmd_pol) begin
      mo <= {mo[30:0], lnk.mosi};
      mi <= {mi[30:0], lnk.miso};
    end
    if (cyc == LIMIT) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic push(input logic [7:0] b);
    @(negedge clk);
    wr_valid = 1'h1;
    wr_data = b;
    while (wr_ready !== 1'h1) @(negedge clk);
    @(negedge clk);
    wr_valid = 1'h0;
  endtask : push

  task automatic run(input logic rd, input logic pol, input logic [5:0] a, input logic [7:0] n);
    @(negedge clk);
    {cmd_rd, cmd_pol, cmd_addr, cmd_len} = {rd, pol, a, n};
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'h1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'h0;
    while (done !== 1'h1) @(negedge clk);
  endtask : run

  // Hand-driven master on the second link, may stop mid byte on purpose
  task automatic bang(input logic pol, input logic [31:0] v, input int n);
    @(negedge clk);
    lnk_b.sclk = pol;
    repeat (4) @(negedge clk);
    lnk_b.cs_n = 1'h0;
    repeat (4) @(negedge clk);
    for (int k = n - 1; k >= 0; k--) begin
      lnk_b.sclk = !pol;
      lnk_b.mosi = v[k];
      repeat (4) @(negedge clk);
      lnk_b.sclk = pol;
      repeat (4) @(negedge clk);
    end
    lnk_b.cs_n = 1'h1;
    lnk_b.mosi = !lnk_b.mosi; // Released line must not keep the last bit
    repeat (8) @(negedge clk);
  endtask : bang

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, en, cmd_valid, cmd_rd, cmd_pol, wr_valid, cmd_addr, cmd_len, wr_data} = {3'h2, 3'h0, 22'h000000};
    {lnk_b.sclk, lnk_b.cs_n, lnk_b.mosi} = 3'h6;
    foreach (regs[i]) regs[i] = 8'h00;
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      r = rows[i];
      wq.delete();
      rq.delete();
      aq.delete();
      if (!r.rd) for (int k = 0; k < r.n; k++) push(r.d[15 - 8 * k -: 8]);
      run(r.rd, r.pol, r.a, r.n);
      check("header", {8'h00, mo[8 * r.n +: 8]}, {8'h00, r.rd, 1'h0, r.a});
      check("idle clock", {15'h0000, lnk.sclk}, {15'h0000, r.pol});
      check("byte count", r.rd ? 16'(rq.size()) : 16'(wq.size()), {8'h00, r.n});
      check("fetch count", 16'(aq.size()), r.rd ? {8'h00, r.n} + 16'h0001 : 16'h0000);
      for (int k = 0; k < r.n; k++) begin
        check("wire byte", {8'h00, r.rd ? mi[8 * (r.n - 1 - k) +: 8] : mo[8 * (r.n - 1 - k) +: 8]},
          {8'h00, r.d[15 - 8 * k -: 8]});
        if (r.rd) check("fetch addr", {10'h000, aq[k]}, {10'h000, r.a + k[5:0]});
        if (r.rd) check("read byte", {8'h00, rq[k]}, {8'h00, r.d[15 - 8 * k -: 8]});
        else check("reg write", {2'h0, wq[k]}, {2'h0, r.a + k[5:0], r.d[15 - 8 * k -: 8]});
      end
    end
    // Fill the FIFO until it refuses, then stall the frame on an empty FIFO
    wq.delete();
    for (int k = 0; k < 4; k++) push(8'h40 + k[7:0]);
    check("fifo full", {15'h0000, wr_ready}, 16'h0000);
    fork
      run(1'h0, 1'h0, 6'h20, 8'h05);
      begin
        repeat (400) @(negedge clk);
        push(8'h44);
      end
    join
    for (int k = 0; k < 5; k++) check("stalled write", {2'h0, wq[k]}, {2'h0, 6'h20 + k[5:0], 8'h40 + k[7:0]});
    // Reset in mid frame, then a fresh read must work
    fork
      run(1'h1, 1'h0, 6'h20, 8'h02);
    join_none
    repeat (60) @(negedge clk);
    rst_n = 1'h0;
    disable fork;
    @(negedge clk);
    cmd_valid = 1'h0;
    check("reset link", {12'h000, lnk.cs_n, lnk.sclk, lnk.miso_oe, cmd_ready}, 16'h0008);
    repeat (4) @(negedge clk);
    rst_n = 1'h1;
    repeat (10) @(negedge clk);
    rq.delete();
    run(1'h1, 1'h1, 6'h21, 8'h01);
    check("read after reset", {8'h00, rq[0]}, 16'h0041);
    // Second link: a whole byte then a cut byte, then a header with a cut byte
    bang(1'h1, {13'h0000, 8'h07, 8'h5A, 3'h5}, 19);
    check("clock high frame", {2'h0, addr_b, wd_b}, 16'h075A);
    bang(1'h0, {19'h00000, 8'h09, 5'h1F}, 13);
    check("partial byte", 16'(wr_cnt2), 16'h0001);
    print_verdict();
  end
endmodule : spi_slave_register_port_tb_top

`default_nettype wire
